// File: core/leadoff_cfg_pkg.sv
// Overview of operation
// - Lead-off at index 03, channel one 04
// - Threshold 7:5, current 3:2, ac/dc bit 0
// - Threshold code gives paired comparator levels
// - Current code: 6nA, 22nA, 6uA, 22uA
// - Bit 0 selects ac at rate/4
// - Powerdown 7, gain 6:4, input 3:0
// - Powerdown bit 1 powers channel down
// - Gain code maps to gain, 111 undefined
// - Input select decode, 1010 reserved
// - Channel one register resets to zero
package leadoff_cfg_pkg;

    localparam logic [7:0]  LEAD_OFF_INDEX      = 8'h03;
    localparam logic [7:0]  CHANNEL_ONE_INDEX   = 8'h04;
    localparam logic [7:0]  STATUS_INDEX        = 8'h07;
    localparam logic [7:0]  UNMAPPED_INDEX      = 8'hff;

    localparam int          THRESH_MSB          = 7;
    localparam int          THRESH_LSB          = 5;
    localparam int          FIXED_ONE_BIT       = 4;
    localparam int          CURRENT_MSB         = 3;
    localparam int          CURRENT_LSB         = 2;
    localparam int          FIXED_ZERO_BIT      = 1;
    localparam int          AC_DC_BIT           = 0;
    localparam int          POWERDOWN_BIT       = 7;
    localparam int          GAIN_MSB            = 6;
    localparam int          GAIN_LSB            = 4;
    localparam int          INSEL_MSB           = 3;
    localparam int          INSEL_LSB           = 0;

    localparam logic [7:0]  LEAD_OFF_RESET      = 8'h10;
    localparam logic [7:0]  CHANNEL_ONE_RESET   = 8'h00;

    localparam int          STAT_PHASE_BIT      = 0;
    localparam int          STAT_ACTIVE_BIT     = 1;
    localparam int          STAT_GAIN_UNDEF_BIT = 2;
    localparam int          STAT_INSEL_RSV_BIT  = 3;
    localparam int          STAT_SUPPLY_GAIN    = 4;
    localparam int          STAT_PD_UNSHORTED   = 5;

    localparam logic [9:0]  PERMILLE_FULL       = 10'h3e8;
    localparam logic [9:0]  THRESH_POS_PERMILLE [8] = '{
        10'h3b6, 10'h39d, 10'h384, 10'h36b, 10'h352, 10'h320, 10'h2ee, 10'h2bc
    };
    localparam logic [15:0] CURRENT_NANOAMP [4] = '{
        16'h0006, 16'h0016, 16'h1770, 16'h55f0
    };
    localparam logic [3:0]  GAIN_VALUE [8] = '{
        4'h6, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hc, 4'h0
    };
    localparam logic [2:0]  GAIN_UNITY          = 3'h1;
    localparam logic [2:0]  GAIN_UNDEFINED      = 3'h7;
    localparam logic [3:0]  INSEL_SHORTED       = 4'h1;
    localparam logic [3:0]  INSEL_SUPPLY        = 4'h3;
    localparam logic [3:0]  INSEL_LAST_DEFINED  = 4'h9;
    localparam int          INSEL_CODES         = 10;

    // Rate/4 square wave: half period is two output samples
    localparam logic [1:0]  TOGGLE_TICKS        = 2'h2;

endpackage

// File: core/excitation_if.sv
interface excitation_if;
    logic sample_tick;
    logic ac_mode;
    logic phase;
    logic active;

    modport ctrl (
        output sample_tick,
        output ac_mode,
        input  phase,
        input  active
    );
    modport gen (
        input  sample_tick,
        input  ac_mode,
        output phase,
        output active
    );
endinterface

// File: core/ac_excitation_gen.sv
module ac_excitation_gen (
    input  wire logic  hclk,
    input  wire logic  hresetn,
    excitation_if.gen  exc
);
    logic [1:0] count;
    logic       phase;
    logic [1:0] next_count;
    logic       next_phase;

    assign exc.phase  = phase;
    assign exc.active = exc.ac_mode;

    always_comb begin
        next_count = count;
        next_phase = phase;
        if (!exc.ac_mode) begin
            // Dc mode holds a steady level, restart cleanly on re-entry
            next_count = 2'h0;
            next_phase = 1'b0;
        end else if (exc.sample_tick) begin
            if (count + 2'h1 == leadoff_cfg_pkg::TOGGLE_TICKS) begin
                next_count = 2'h0;
                next_phase = ~phase;
            end else begin
                next_count = count + 2'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= 2'h0;
            phase <= 1'b0;
        end else begin
            count <= next_count;
            phase <= next_phase;
        end
    end
endmodule

// File: core/leadoff_channel_config_regs.sv
// Implementation choice: register access over AHB-Lite.
module leadoff_channel_config_regs (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        sample_tick,
    output logic [2:0]       comparator_threshold_code,
    output logic [9:0]       threshold_pos_permille,
    output logic [9:0]       threshold_neg_permille,
    output logic [1:0]       excitation_current_code,
    output logic [15:0]      excitation_current_na,
    output logic             ac_dc_detect_select,
    output logic             excitation_phase,
    output logic             channel_one_powerdown,
    output logic [2:0]       channel_one_gain_code,
    output logic [3:0]       channel_one_gain_value,
    output logic [3:0]       channel_one_input_select,
    output logic [9:0]       input_select_onehot,
    output logic             input_select_reserved
);
    // Bus and register state
    logic [7:0]  lead_off_control;
    logic [7:0]  channel_one_settings;
    logic        wr_pending;
    logic [7:0]  wr_index;
    logic [7:0]  next_lead_off_control;
    logic [7:0]  next_channel_one_settings;
    logic        next_wr_pending;
    logic [7:0]  next_wr_index;
    logic [31:0] next_hrdata;
    logic [7:0]  addr_index;
    logic        addr_phase;
    logic [7:0]  status;

    // Decoded outputs
    logic [9:0]  next_pos;
    logic [9:0]  next_neg;
    logic [15:0] next_current_na;
    logic [3:0]  next_gain_value;
    logic [9:0]  next_onehot;
    logic        next_reserved;
    logic        next_phase;
    logic        gain_undefined;
    logic        supply_gain_bad;
    logic        pd_unshorted;

    excitation_if exc ();

    ac_excitation_gen gen_inst (
        .hclk    (hclk),
        .hresetn (hresetn),
        .exc     (exc)
    );

    assign exc.sample_tick = sample_tick;
    assign exc.ac_mode     = lead_off_control[leadoff_cfg_pkg::AC_DC_BIT];

    // Upper address bits and the low two bits must be clear; anything else is unmapped
    assign addr_index = (haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0)
                        ? haddr[9:2] : leadoff_cfg_pkg::UNMAPPED_INDEX;
    assign addr_phase = hsel && htrans[1] && hready;

    // Host misuse flags: device stores the value regardless
    assign gain_undefined  = channel_one_settings[leadoff_cfg_pkg::GAIN_MSB:
                             leadoff_cfg_pkg::GAIN_LSB] == leadoff_cfg_pkg::GAIN_UNDEFINED;
    assign supply_gain_bad = channel_one_settings[leadoff_cfg_pkg::INSEL_MSB:
                             leadoff_cfg_pkg::INSEL_LSB] == leadoff_cfg_pkg::INSEL_SUPPLY
                             && channel_one_settings[leadoff_cfg_pkg::GAIN_MSB:
                             leadoff_cfg_pkg::GAIN_LSB] != leadoff_cfg_pkg::GAIN_UNITY;
    assign pd_unshorted    = channel_one_settings[leadoff_cfg_pkg::POWERDOWN_BIT]
                             && channel_one_settings[leadoff_cfg_pkg::INSEL_MSB:
                             leadoff_cfg_pkg::INSEL_LSB] != leadoff_cfg_pkg::INSEL_SHORTED;

    always_comb begin
        status = 8'h00;
        status[leadoff_cfg_pkg::STAT_PHASE_BIT]      = exc.phase;
        status[leadoff_cfg_pkg::STAT_ACTIVE_BIT]     = exc.active;
        status[leadoff_cfg_pkg::STAT_GAIN_UNDEF_BIT] = gain_undefined;
        status[leadoff_cfg_pkg::STAT_INSEL_RSV_BIT]  = input_select_reserved;
        status[leadoff_cfg_pkg::STAT_SUPPLY_GAIN]    = supply_gain_bad;
        status[leadoff_cfg_pkg::STAT_PD_UNSHORTED]   = pd_unshorted;
    end

    // Bus group: write lands in data phase, read data forms in address phase
    always_comb begin
        next_lead_off_control     = lead_off_control;
        next_channel_one_settings = channel_one_settings;
        next_wr_pending           = 1'b0;
        next_wr_index             = wr_index;
        next_hrdata               = hrdata;
        if (wr_pending) begin
            // Whole byte kept, fixed and reserved codes included
            case (wr_index)
                leadoff_cfg_pkg::LEAD_OFF_INDEX: begin
                    next_lead_off_control = hwdata[7:0];
                end
                leadoff_cfg_pkg::CHANNEL_ONE_INDEX: begin
                    next_channel_one_settings = hwdata[7:0];
                end
                default: begin
                end
            endcase
        end
        if (addr_phase) begin
            next_wr_pending = hwrite;
            next_wr_index   = addr_index;
            next_hrdata     = 32'h0000_0000;
            // Reads see a write finishing in this same cycle
            if (!hwrite) begin
                case (addr_index)
                    leadoff_cfg_pkg::LEAD_OFF_INDEX: begin
                        next_hrdata[7:0] = next_lead_off_control;
                    end
                    leadoff_cfg_pkg::CHANNEL_ONE_INDEX: begin
                        next_hrdata[7:0] = next_channel_one_settings;
                    end
                    leadoff_cfg_pkg::STATUS_INDEX: begin
                        next_hrdata[7:0] = status;
                    end
                    default: begin
                        next_hrdata = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lead_off_control     <= leadoff_cfg_pkg::LEAD_OFF_RESET;
            channel_one_settings <= leadoff_cfg_pkg::CHANNEL_ONE_RESET;
            wr_pending           <= 1'b0;
            wr_index             <= 8'h00;
            hrdata               <= 32'h0000_0000;
            hreadyout            <= 1'b1;
            hresp                <= 1'b0;
        end else begin
            lead_off_control     <= next_lead_off_control;
            channel_one_settings <= next_channel_one_settings;
            wr_pending           <= next_wr_pending;
            wr_index             <= next_wr_index;
            hrdata               <= next_hrdata;
            hreadyout            <= 1'b1;
            hresp                <= 1'b0;
        end
    end

    // Per-code input select decode
    genvar i;
    generate
        for (i = 0; i < leadoff_cfg_pkg::INSEL_CODES; i++) begin : g_insel
            assign next_onehot[i] = channel_one_settings[leadoff_cfg_pkg::INSEL_MSB:
                                    leadoff_cfg_pkg::INSEL_LSB] == 4'(i);
        end
    endgenerate

    // Decode group: one cycle behind the stored fields
    always_comb begin
        next_pos = leadoff_cfg_pkg::THRESH_POS_PERMILLE[lead_off_control[
                   leadoff_cfg_pkg::THRESH_MSB:leadoff_cfg_pkg::THRESH_LSB]];
        next_neg = leadoff_cfg_pkg::PERMILLE_FULL - next_pos;
        next_current_na = leadoff_cfg_pkg::CURRENT_NANOAMP[lead_off_control[
                          leadoff_cfg_pkg::CURRENT_MSB:leadoff_cfg_pkg::CURRENT_LSB]];
        next_gain_value = leadoff_cfg_pkg::GAIN_VALUE[channel_one_settings[
                          leadoff_cfg_pkg::GAIN_MSB:leadoff_cfg_pkg::GAIN_LSB]];
        next_reserved = channel_one_settings[leadoff_cfg_pkg::INSEL_MSB:
                        leadoff_cfg_pkg::INSEL_LSB] > leadoff_cfg_pkg::INSEL_LAST_DEFINED;
        next_phase = exc.phase;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comparator_threshold_code <= 3'h0;
            threshold_pos_permille    <= 10'h000;
            threshold_neg_permille    <= 10'h000;
            excitation_current_code   <= 2'h0;
            excitation_current_na     <= 16'h0000;
            ac_dc_detect_select       <= 1'b0;
            excitation_phase          <= 1'b0;
            channel_one_powerdown     <= 1'b0;
            channel_one_gain_code     <= 3'h0;
            channel_one_gain_value    <= 4'h0;
            channel_one_input_select  <= 4'h0;
            input_select_onehot       <= 10'h000;
            input_select_reserved     <= 1'b0;
        end else begin
            comparator_threshold_code <= lead_off_control[leadoff_cfg_pkg::THRESH_MSB:
                                         leadoff_cfg_pkg::THRESH_LSB];
            threshold_pos_permille    <= next_pos;
            threshold_neg_permille    <= next_neg;
            excitation_current_code   <= lead_off_control[leadoff_cfg_pkg::CURRENT_MSB:
                                         leadoff_cfg_pkg::CURRENT_LSB];
            excitation_current_na     <= next_current_na;
            ac_dc_detect_select       <= lead_off_control[leadoff_cfg_pkg::AC_DC_BIT];
            excitation_phase          <= next_phase;
            channel_one_powerdown     <= channel_one_settings[
                                         leadoff_cfg_pkg::POWERDOWN_BIT];
            channel_one_gain_code     <= channel_one_settings[leadoff_cfg_pkg::GAIN_MSB:
                                         leadoff_cfg_pkg::GAIN_LSB];
            channel_one_gain_value    <= next_gain_value;
            channel_one_input_select  <= channel_one_settings[leadoff_cfg_pkg::INSEL_MSB:
                                         leadoff_cfg_pkg::INSEL_LSB];
            input_select_onehot       <= next_onehot;
            input_select_reserved     <= next_reserved;
        end
    end
endmodule

// File: bench/leadoff_cfg_chk.sv
module leadoff_cfg_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic [2:0]  comparator_threshold_code,
    input wire logic [9:0]  threshold_pos_permille,
    input wire logic [9:0]  threshold_neg_permille,
    input wire logic [1:0]  excitation_current_code,
    input wire logic [15:0] excitation_current_na,
    input wire logic        ac_dc_detect_select,
    input wire logic        excitation_phase,
    input wire logic        channel_one_powerdown,
    input wire logic [2:0]  channel_one_gain_code,
    input wire logic [3:0]  channel_one_gain_value,
    input wire logic [3:0]  channel_one_input_select,
    input wire logic [9:0]  input_select_onehot,
    input wire logic        input_select_reserved
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [9:0]  POS [8] = '{10'h3b6, 10'h39d, 10'h384, 10'h36b,
                                       10'h352, 10'h320, 10'h2ee, 10'h2bc};
    localparam logic [15:0] CUR [4] = '{16'h0006, 16'h0016, 16'h1770, 16'h55f0};
    localparam logic [3:0]  GAIN [8] = '{4'h6, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hc, 4'h0};
    // Decoded outputs hold zero through reset, so skip the first edge after release
    logic live;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            live <= 1'h0;
        end else begin
            live <= 1'h1;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_thresh_pair: assert property (live |-> threshold_pos_permille == POS[comparator_threshold_code]
        && threshold_neg_permille == 10'h3e8 - POS[comparator_threshold_code])
        else $error("threshold levels wrong");
    a_current_map: assert property (live |-> excitation_current_na == CUR[excitation_current_code])
        else $error("current magnitude wrong");
    a_gain_map: assert property (live |-> channel_one_gain_value == GAIN[channel_one_gain_code])
        else $error("gain value wrong");
    a_insel_decode: assert property (live |-> input_select_onehot ==
        (channel_one_input_select <= 4'h9 ? 10'h001 << channel_one_input_select : 10'h000)
        && input_select_reserved == (channel_one_input_select > 4'h9))
        else $error("input select decode wrong");
    a_dc_phase: assert property (!ac_dc_detect_select [*2] |-> !excitation_phase)
        else $error("phase moves in dc mode");
    a_lead_write: assert property (hsel && htrans[1] && hready && hwrite
        && haddr == 32'h0000_000c ##1 1'h1 |-> ##2 ($past(hwdata, 2) & 32'h0000_00ed)
        == 32'({comparator_threshold_code, 1'h0, excitation_current_code, 1'h0,
        ac_dc_detect_select})) else $error("lead-off fields not as written");
    a_chan_write: assert property (hsel && htrans[1] && hready && hwrite
        && haddr == 32'h0000_0010 ##1 1'h1 |-> ##2 ($past(hwdata, 2) & 32'h0000_00ff)
        == 32'({channel_one_powerdown, channel_one_gain_code, channel_one_input_select}))
        else $error("channel fields not as written");
    a_read_back: assert property (hsel && htrans[1] && hready && !hwrite
        && haddr == 32'h0000_0010 |=> ##1 $past(hrdata)
        == 32'({channel_one_powerdown, channel_one_gain_code, channel_one_input_select}))
        else $error("channel read data wrong");
endmodule
bind leadoff_channel_config_regs leadoff_cfg_chk chk (.*);

// File: bench/host_model.sv
module host_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        hsel   = 1'h0;
        haddr  = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
    end
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] data,
                        output logic [31:0] rdata);
        @(posedge hclk);
        hsel   <= 1'h1;
        haddr  <= addr;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        // Released lines other than hwrite and hsize never keep the old value
        haddr  <= ~addr;
        hwdata <= wr ? data : ~hwdata;
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        rdata = hrdata;
        hwdata <= ~hwdata;
    endtask
    task automatic write_leadoff(input logic [2:0] thr, input logic [1:0] cur, input logic ac);
        logic [31:0] unused;
        xfer(1'h1, 32'h0000_000c, {24'h00_0000, thr, 1'h1, cur, 1'h0, ac}, unused);
    endtask
    task automatic write_channel(input logic pd, input logic [2:0] gain, input logic [3:0] sel);
        logic [31:0] unused;
        if (sel == 4'h3) gain = 3'h1;
        if (pd) begin
            xfer(1'h1, 32'h0000_0010, {24'h00_0000, 1'h0, gain, 4'h1}, unused);
            sel = 4'h1;
        end
        xfer(1'h1, 32'h0000_0010, {24'h00_0000, pd, gain, sel}, unused);
    endtask
endmodule

// File: bench/leadoff_channel_config_regs_tb.sv
module leadoff_channel_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        sample_tick;
    logic [2:0]  comparator_threshold_code;
    logic [9:0]  threshold_pos_permille;
    logic [9:0]  threshold_neg_permille;
    logic [1:0]  excitation_current_code;
    logic [15:0] excitation_current_na;
    logic        ac_dc_detect_select;
    logic        excitation_phase;
    logic        channel_one_powerdown;
    logic [2:0]  channel_one_gain_code;
    logic [3:0]  channel_one_gain_value;
    logic [3:0]  channel_one_input_select;
    logic [9:0]  input_select_onehot;
    logic        input_select_reserved;
    int          num_errors = 0;
    int          n_checks = 0;
    localparam logic [9:0]  POS [8] = '{10'h3b6, 10'h39d, 10'h384, 10'h36b,
                                       10'h352, 10'h320, 10'h2ee, 10'h2bc};
    localparam logic [15:0] CUR [4] = '{16'h0006, 16'h0016, 16'h1770, 16'h55f0};
    localparam logic [3:0]  GAIN [8] = '{4'h6, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hc, 4'h0};

    leadoff_channel_config_regs dut (.hready(hreadyout), .*);
    host_model host (.hready(hreadyout), .*);

    initial begin
        hclk = 1'h0;
        forever #50 hclk = ~hclk;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_check(input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] rv;
        host.xfer(1'h0, addr, 32'h0000_0000, rv);
        check("read data", exp, rv);
    endtask
    // Fields show one edge after the data phase ends; settle waits two
    task automatic settle();
        repeat (2) @(posedge hclk);
        #1;
    endtask
    task automatic pulse();
        @(posedge hclk);
        sample_tick <= 1'h1;
        @(posedge hclk);
        sample_tick <= 1'h0;
        settle();
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #2_000_000;
        num_errors++;
        complete_run();
    end
    initial begin
        logic [31:0] rv;
        logic [2:0]  g;
        hresetn     = 1'h0;
        sample_tick = 1'h0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'h1;
        settle();
        check("pos level", 32'h0000_03b6, threshold_pos_permille);
        check("neg level", 32'h0000_0032, threshold_neg_permille);
        check("current", 32'h0000_0006, excitation_current_na);
        check("gain", 32'h0000_0006, channel_one_gain_value);
        check("onehot", 32'h0000_0001, input_select_onehot);
        check("powerdown", 32'h0000_0000, channel_one_powerdown);
        rd_check(32'h0000_000c, 32'h0000_0010);
        rd_check(32'h0000_0010, 32'h0000_0000);
        for (int k = 0; k < 8; k++) begin
            host.write_leadoff(3'(k), 2'(k), 1'h0);
            settle();
            check("pos level", POS[k], threshold_pos_permille);
            check("neg level", 10'h3e8 - POS[k], threshold_neg_permille);
            check("current", CUR[k % 4], excitation_current_na);
            rd_check(32'h0000_000c, {24'h00_0000, 3'(k), 1'h1, 2'(k), 2'h0});
        end
        for (int k = 0; k < 16; k++) begin
            // Supply input only ever paired with unity gain
            g = (k == 3) ? 3'h1 : 3'(k);
            host.write_channel(1'h0, g, 4'(k));
            settle();
            check("gain", GAIN[g], channel_one_gain_value);
            check("onehot", k < 10 ? 10'h001 << k : 10'h000, input_select_onehot);
            check("reserved", k > 9, input_select_reserved);
            rd_check(32'h0000_0010, {24'h00_0000, 1'h0, g, 4'(k)});
        end
        rd_check(32'h0000_001c, 32'h0000_000c);
        host.write_channel(1'h0, 3'h5, 4'h3);
        settle();
        check("gain", 32'h0000_0001, channel_one_gain_value);
        host.write_channel(1'h1, 3'h2, 4'h5);
        settle();
        check("powerdown", 32'h0000_0001, channel_one_powerdown);
        rd_check(32'h0000_0010, 32'h0000_00a1);
        // Unmapped and misaligned writes must leave both registers alone
        host.xfer(1'h1, 32'h0000_03fc, 32'h0000_00ff, rv);
        host.xfer(1'h1, 32'h0000_000d, 32'h0000_00ff, rv);
        rd_check(32'h0000_03fc, 32'h0000_0000);
        rd_check(32'h0000_000c, 32'h0000_00fc);
        rd_check(32'h0000_0010, 32'h0000_00a1);
        host.write_leadoff(3'h0, 2'h0, 1'h1);
        settle();
        check("ac select", 32'h0000_0001, ac_dc_detect_select);
        for (int k = 1; k <= 4; k++) begin
            pulse();
            check("phase", (k >> 1) & 1, excitation_phase);
        end
        pulse();
        pulse();
        rd_check(32'h0000_001c, 32'h0000_0003);
        host.write_leadoff(3'h0, 2'h0, 1'h0);
        settle();
        check("phase", 32'h0000_0000, excitation_phase);
        pulse();
        pulse();
        check("phase", 32'h0000_0000, excitation_phase);
        // Mid-run reset must bring every field back to its default
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        settle();
        check("gain", 32'h0000_0006, channel_one_gain_value);
        rd_check(32'h0000_000c, 32'h0000_0010);
        rd_check(32'h0000_0010, 32'h0000_0000);
        complete_run();
    end
endmodule
